// file: design/dpir_map.svh
// How it works
// - Pins seven to four show general bits, or channel ready signals when routed.
// - Pin three field picks general bit, counter output, B transmit or receive clock.
// - Pin two field picks general bit, A transmit 16X, A transmit 1X, A receive 1X.
// - Change register: upper nibble tells which inputs changed, lower nibble their levels.
// - Flag register holds eight interrupt conditions in the fixed bit order.
// - Enable register has one bit per flag, 1 turns that interrupt on.
// - Preload high byte holds counter preload bits fifteen to eight.
// - Preload low byte holds counter preload bits seven to zero.
// - Vector register stores the host value and presents it as interrupt vector.
// - Reset clears status, enables, flags, general bits, routing; vector becomes 0F.
`ifndef DPIR_MAP_SVH
`define DPIR_MAP_SVH

// Register offsets
`define DPIR_OFS_ROUTING 4'h0
`define DPIR_OFS_CHANGE 4'h1
`define DPIR_OFS_FLAGS 4'h2
`define DPIR_OFS_ENABLES 4'h3
`define DPIR_OFS_PRE_HI 4'h4
`define DPIR_OFS_PRE_LO 4'h5
`define DPIR_OFS_VECTOR 4'h6
`define DPIR_OFS_GEN_OUT 4'h7

// Reset values
`define DPIR_RST_ROUTING 8'h00
`define DPIR_RST_ENABLES 8'h00
`define DPIR_RST_FLAGS 8'h00
`define DPIR_RST_GEN_OUT 8'h00
`define DPIR_RST_VECTOR 8'h0F
`define DPIR_RST_PRELOAD 8'h00
`define DPIR_RST_STATUS 8'h00

// Routing register fields
`define DPIR_RT_LINE7 7
`define DPIR_RT_LINE6 6
`define DPIR_RT_LINE5 5
`define DPIR_RT_LINE4 4
`define DPIR_RT_LINE3_HI 3
`define DPIR_RT_LINE3_LO 2
`define DPIR_RT_LINE2_HI 1
`define DPIR_RT_LINE2_LO 0

// Flag and enable bit positions
`define DPIR_FL_IN_CHANGE 7
`define DPIR_FL_BRK_B 6
`define DPIR_FL_RX_B 5
`define DPIR_FL_TX_B 4
`define DPIR_FL_CT_RDY 3
`define DPIR_FL_BRK_A 2
`define DPIR_FL_RX_A 1
`define DPIR_FL_TX_A 0

`endif

// file: design/dpir_pkg.sv
package dpir_pkg;
    typedef logic [7:0] dpir_byte_t;
    typedef logic [3:0] dpir_addr_t;
    typedef logic [3:0] dpir_nib_t;

    typedef enum logic [1:0] {
        DPIR_LINE3_GEN = 2'b00,
        DPIR_LINE3_CT = 2'b01,
        DPIR_LINE3_TXB1 = 2'b10,
        DPIR_LINE3_RXB1 = 2'b11
    } dpir_line3_sel_e;

    typedef enum logic [1:0] {
        DPIR_LINE2_GEN = 2'b00,
        DPIR_LINE2_TXA16 = 2'b01,
        DPIR_LINE2_TXA1 = 2'b10,
        DPIR_LINE2_RXA1 = 2'b11
    } dpir_line2_sel_e;

    typedef struct packed {
        logic armed;
        logic last_level;
        logic changed;
        logic pulse;
    } dpir_edge_s;

    typedef struct packed {
        dpir_byte_t routing;
        dpir_byte_t enables;
        dpir_byte_t flags;
        dpir_byte_t gen_out;
        dpir_byte_t pre_hi;
        dpir_byte_t pre_lo;
        dpir_byte_t vector;
        dpir_byte_t channel_status;
        dpir_byte_t pins;
        dpir_byte_t rdata;
        logic irq;
    } dpir_regs_s;
endpackage

// file: design/dpir_route_if.sv
`timescale 1ns/1ps
interface dpir_route_if;
    logic [7:0] routing;
    logic [7:0] gen_out;
    logic tx_rdy_a;
    logic tx_rdy_b;
    logic rx_rdy_a;
    logic rx_rdy_b;
    logic ct_out;
    logic txc_a16;
    logic txc_a1;
    logic rxc_a1;
    logic txc_b1;
    logic rxc_b1;
    logic [7:0] pins;

    modport ctrl (
        output routing, gen_out, tx_rdy_a, tx_rdy_b, rx_rdy_a, rx_rdy_b,
        output ct_out, txc_a16, txc_a1, rxc_a1, txc_b1, rxc_b1,
        input pins
    );
    modport mux (
        input routing, gen_out, tx_rdy_a, tx_rdy_b, rx_rdy_a, rx_rdy_b,
        input ct_out, txc_a16, txc_a1, rxc_a1, txc_b1, rxc_b1,
        output pins
    );
endinterface

// file: design/dpir_pin_mux.sv
`timescale 1ns/1ps
`include "dpir_map.svh"
module dpir_pin_mux (
    // Steering sources and steered pins
    dpir_route_if.mux rt
);
    import dpir_pkg::*;

    dpir_line3_sel_e sel3;
    dpir_line2_sel_e sel2;

    always_comb begin
        sel3 = dpir_line3_sel_e'(rt.routing[`DPIR_RT_LINE3_HI:`DPIR_RT_LINE3_LO]);
        sel2 = dpir_line2_sel_e'(rt.routing[`DPIR_RT_LINE2_HI:`DPIR_RT_LINE2_LO]);
        rt.pins = rt.gen_out;
        if (rt.routing[`DPIR_RT_LINE7]) begin
            rt.pins[7] = rt.tx_rdy_b;
        end
        if (rt.routing[`DPIR_RT_LINE6]) begin
            rt.pins[6] = rt.tx_rdy_a;
        end
        if (rt.routing[`DPIR_RT_LINE5]) begin
            rt.pins[5] = rt.rx_rdy_b;
        end
        if (rt.routing[`DPIR_RT_LINE4]) begin
            rt.pins[4] = rt.rx_rdy_a;
        end
        case (sel3)
            DPIR_LINE3_GEN: rt.pins[3] = rt.gen_out[3];
            DPIR_LINE3_CT: rt.pins[3] = rt.ct_out;
            DPIR_LINE3_TXB1: rt.pins[3] = rt.txc_b1;
            DPIR_LINE3_RXB1: rt.pins[3] = rt.rxc_b1;
            default: rt.pins[3] = rt.gen_out[3];
        endcase
        case (sel2)
            DPIR_LINE2_GEN: rt.pins[2] = rt.gen_out[2];
            DPIR_LINE2_TXA16: rt.pins[2] = rt.txc_a16;
            DPIR_LINE2_TXA1: rt.pins[2] = rt.txc_a1;
            DPIR_LINE2_RXA1: rt.pins[2] = rt.rxc_a1;
            default: rt.pins[2] = rt.gen_out[2];
        endcase
    end
endmodule

// file: design/dpir_in_change.sv
`timescale 1ns/1ps
module dpir_in_change (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Line and host clear
    input wire logic level,
    input wire logic clear,
    // Status
    output logic changed,
    output logic pulse
);
    import dpir_pkg::*;

    dpir_edge_s st_ff;
    dpir_edge_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.armed = 1'b1;
        nxt_st.last_level = level;
        // First sample after reset only records the level
        nxt_st.pulse = st_ff.armed && (level != st_ff.last_level);
        // A change seen in the clearing cycle stays reported
        nxt_st.changed = (st_ff.changed && !clear) || nxt_st.pulse;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign changed = st_ff.changed;
    assign pulse = st_ff.pulse;
endmodule

// file: design/dpir_top.sv
`timescale 1ns/1ps
`include "dpir_map.svh"
module dpir_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire dpir_pkg::dpir_addr_t reg_addr,
    input wire dpir_pkg::dpir_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output dpir_pkg::dpir_byte_t reg_rdata,
    // Input lines zero to three
    input wire dpir_pkg::dpir_nib_t in_lines,
    // Channel and counter sources
    input wire logic transmit_ready_chan_a,
    input wire logic transmit_ready_chan_b,
    input wire logic receive_ready_full_chan_a,
    input wire logic receive_ready_full_chan_b,
    input wire logic break_change_chan_a,
    input wire logic break_change_chan_b,
    input wire logic counter_ready,
    input wire logic counter_out,
    input wire logic transmit_clock_chan_a_16x,
    input wire logic transmit_clock_chan_a,
    input wire logic receive_clock_chan_a,
    input wire logic transmit_clock_chan_b,
    input wire logic receive_clock_chan_b,
    // Output lines zero to seven
    output dpir_pkg::dpir_byte_t out_lines,
    // Counter preload, vector and channel status
    output dpir_pkg::dpir_byte_t counter_preload_high,
    output dpir_pkg::dpir_byte_t counter_preload_low,
    output dpir_pkg::dpir_byte_t interrupt_vector,
    output dpir_pkg::dpir_byte_t channel_status,
    // Interrupt
    output logic irq
);
    import dpir_pkg::*;

    dpir_regs_s r_ff;
    dpir_regs_s nxt_r;

    dpir_route_if rt ();

    logic wr_routing;
    logic wr_enables;
    logic wr_flags;
    logic wr_pre_hi;
    logic wr_pre_lo;
    logic wr_vector;
    logic wr_gen_out;
    logic rd_change;
    logic any_change;
    dpir_nib_t delta;
    dpir_nib_t delta_pulse;
    dpir_byte_t events;
    dpir_byte_t flags_next;
    dpir_byte_t read_mux;

    // Write decode
    always_comb begin
        wr_routing = reg_wr && (reg_addr == `DPIR_OFS_ROUTING);
        wr_enables = reg_wr && (reg_addr == `DPIR_OFS_ENABLES);
        wr_flags = reg_wr && (reg_addr == `DPIR_OFS_FLAGS);
        wr_pre_hi = reg_wr && (reg_addr == `DPIR_OFS_PRE_HI);
        wr_pre_lo = reg_wr && (reg_addr == `DPIR_OFS_PRE_LO);
        wr_vector = reg_wr && (reg_addr == `DPIR_OFS_VECTOR);
        wr_gen_out = reg_wr && (reg_addr == `DPIR_OFS_GEN_OUT);
        rd_change = reg_rd && (reg_addr == `DPIR_OFS_CHANGE);
    end

    // Change detectors, one per input line
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_line
            dpir_in_change u_chg (
                .clock(clock),
                .rst(rst),
                .level(in_lines[gi]),
                .clear(rd_change),
                .changed(delta[gi]),
                .pulse(delta_pulse[gi])
            );
        end
    endgenerate

    assign any_change = |delta_pulse;

    // Pin steering
    assign rt.routing = r_ff.routing;
    assign rt.gen_out = r_ff.gen_out;
    assign rt.tx_rdy_a = transmit_ready_chan_a;
    assign rt.tx_rdy_b = transmit_ready_chan_b;
    assign rt.rx_rdy_a = receive_ready_full_chan_a;
    assign rt.rx_rdy_b = receive_ready_full_chan_b;
    assign rt.ct_out = counter_out;
    assign rt.txc_a16 = transmit_clock_chan_a_16x;
    assign rt.txc_a1 = transmit_clock_chan_a;
    assign rt.rxc_a1 = receive_clock_chan_a;
    assign rt.txc_b1 = transmit_clock_chan_b;
    assign rt.rxc_b1 = receive_clock_chan_b;

    dpir_pin_mux u_mux (
        .rt(rt.mux)
    );

    // Interrupt conditions in flag order
    always_comb begin
        events = 8'h00;
        events[`DPIR_FL_IN_CHANGE] = any_change;
        events[`DPIR_FL_BRK_B] = break_change_chan_b;
        events[`DPIR_FL_RX_B] = receive_ready_full_chan_b;
        events[`DPIR_FL_TX_B] = transmit_ready_chan_b;
        events[`DPIR_FL_CT_RDY] = counter_ready;
        events[`DPIR_FL_BRK_A] = break_change_chan_a;
        events[`DPIR_FL_RX_A] = receive_ready_full_chan_a;
        events[`DPIR_FL_TX_A] = transmit_ready_chan_a;
    end

    // Write one clears; a condition present in the same cycle keeps its bit
    always_comb begin
        flags_next = r_ff.flags;
        if (wr_flags) begin
            flags_next = r_ff.flags & ~reg_wdata;
        end
        flags_next = flags_next | events;
    end

    // Read data source
    always_comb begin
        case (reg_addr)
            `DPIR_OFS_ROUTING: read_mux = r_ff.routing;
            `DPIR_OFS_CHANGE: read_mux = {delta, in_lines};
            `DPIR_OFS_FLAGS: read_mux = r_ff.flags;
            `DPIR_OFS_ENABLES: read_mux = r_ff.enables;
            `DPIR_OFS_PRE_HI: read_mux = r_ff.pre_hi;
            `DPIR_OFS_PRE_LO: read_mux = r_ff.pre_lo;
            `DPIR_OFS_VECTOR: read_mux = r_ff.vector;
            `DPIR_OFS_GEN_OUT: read_mux = r_ff.gen_out;
            default: read_mux = 8'h00;
        endcase
    end

    // Next state
    always_comb begin
        nxt_r = r_ff;
        if (wr_routing) begin
            nxt_r.routing = reg_wdata;
        end
        if (wr_enables) begin
            nxt_r.enables = reg_wdata;
        end
        if (wr_pre_hi) begin
            nxt_r.pre_hi = reg_wdata;
        end
        if (wr_pre_lo) begin
            nxt_r.pre_lo = reg_wdata;
        end
        if (wr_vector) begin
            nxt_r.vector = reg_wdata;
        end
        if (wr_gen_out) begin
            nxt_r.gen_out = reg_wdata;
        end
        nxt_r.flags = flags_next;
        // Pins follow the steering of the current cycle
        nxt_r.pins = rt.pins;
        // Interrupt tracks the updated flags and enables together
        nxt_r.irq = |(flags_next & nxt_r.enables);
        if (reg_rd) begin
            nxt_r.rdata = read_mux;
        end else begin
            nxt_r.rdata = 8'h00;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r_ff.routing <= `DPIR_RST_ROUTING;
            r_ff.enables <= `DPIR_RST_ENABLES;
            r_ff.flags <= `DPIR_RST_FLAGS;
            r_ff.gen_out <= `DPIR_RST_GEN_OUT;
            r_ff.vector <= `DPIR_RST_VECTOR;
            r_ff.channel_status <= `DPIR_RST_STATUS;
            r_ff.pre_hi <= `DPIR_RST_PRELOAD;
            r_ff.pre_lo <= `DPIR_RST_PRELOAD;
            r_ff.pins <= `DPIR_RST_GEN_OUT;
            r_ff.rdata <= 8'h00;
            r_ff.irq <= 1'b0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = r_ff.rdata;
    assign out_lines = r_ff.pins;
    assign counter_preload_high = r_ff.pre_hi;
    assign counter_preload_low = r_ff.pre_lo;
    assign interrupt_vector = r_ff.vector;
    assign channel_status = r_ff.channel_status;
    assign irq = r_ff.irq;
endmodule

// file: verification/dpir_top_properties.sv
`timescale 1ns/1ps
`include "dpir_map.svh"
module dpir_top_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire dpir_pkg::dpir_addr_t reg_addr,
    input wire dpir_pkg::dpir_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire dpir_pkg::dpir_byte_t reg_rdata,
    // Lines and outputs
    input wire dpir_pkg::dpir_nib_t in_lines,
    input wire logic break_change_chan_b,
    input wire dpir_pkg::dpir_byte_t counter_preload_high,
    input wire dpir_pkg::dpir_byte_t counter_preload_low,
    input wire dpir_pkg::dpir_byte_t interrupt_vector,
    input wire dpir_pkg::dpir_byte_t channel_status,
    input wire logic irq
);
    import dpir_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    chk_vec_write: assert property (reg_wr && reg_addr == `DPIR_OFS_VECTOR |=>
        interrupt_vector == $past(reg_wdata)) else $error("vector not stored");
    chk_vec_read: assert property (reg_rd && reg_addr == `DPIR_OFS_VECTOR |=>
        reg_rdata == $past(interrupt_vector)) else $error("vector read wrong");
    chk_pre_high: assert property (reg_wr && reg_addr == `DPIR_OFS_PRE_HI |=>
        counter_preload_high == $past(reg_wdata)) else $error("preload high wrong");
    chk_pre_low: assert property (reg_wr && reg_addr == `DPIR_OFS_PRE_LO |=>
        counter_preload_low == $past(reg_wdata)) else $error("preload low wrong");
    chk_status_held: assert property (channel_status == 8'h00)
        else $error("channel status not clear");
    chk_change_levels: assert property (reg_rd && reg_addr == `DPIR_OFS_CHANGE |=>
        reg_rdata[3:0] == $past(in_lines)) else $error("input levels wrong");
    chk_flag_sticky: assert property (break_change_chan_b ##1
        (reg_rd && reg_addr == `DPIR_OFS_FLAGS) |=> reg_rdata[6]) else $error("flag not set");
    chk_irq_masked: assert property ((reg_wr && reg_addr == `DPIR_OFS_ENABLES
        && reg_wdata == 8'h00) ##1 !(reg_wr && reg_addr == `DPIR_OFS_ENABLES) |=> !irq)
        else $error("irq with all enables off");
endmodule

bind dpir_top dpir_top_properties u_chk (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .in_lines, .break_change_chan_b, .counter_preload_high,
    .counter_preload_low, .interrupt_vector, .channel_status, .irq);

// file: verification/dpir_host_model.sv
`timescale 1ns/1ps
module dpir_host_model (
    // Clock
    input wire logic clock,
    // Register port toward the device
    output dpir_pkg::dpir_addr_t reg_addr,
    output dpir_pkg::dpir_byte_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    import dpir_pkg::*;
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One strobe cycle, then an idle cycle before the next transfer
    task automatic xfer(input logic w, input dpir_addr_t a, input dpir_byte_t d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
endmodule

// file: verification/duart_port_irq_counter_regs_tb.sv
`timescale 1ns/1ps
`include "dpir_map.svh"
module duart_port_irq_counter_regs_tb;
    import dpir_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    dpir_addr_t reg_addr;
    dpir_byte_t reg_wdata, reg_rdata, out_lines, ct_hi, ct_lo, ivec, chst, d, r, g;
    logic reg_wr, reg_rd, irq;
    dpir_nib_t in_l = 4'h0;
    logic [12:0] src = '0;
    dpir_byte_t exp_q[$];
    logic rd_d = 1'b0;
    int num_errors = 0;
    int checks = 0;
    always #5 clock = ~clock;

    dpir_host_model u_host (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    dpir_top u_dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .in_lines(in_l), .transmit_ready_chan_a(src[0]), .receive_ready_full_chan_a(src[1]),
        .break_change_chan_a(src[2]), .counter_ready(src[3]), .transmit_ready_chan_b(src[4]),
        .receive_ready_full_chan_b(src[5]), .break_change_chan_b(src[6]), .counter_out(src[7]),
        .transmit_clock_chan_a_16x(src[8]), .transmit_clock_chan_a(src[9]),
        .receive_clock_chan_a(src[10]), .transmit_clock_chan_b(src[11]),
        .receive_clock_chan_b(src[12]), .out_lines, .counter_preload_high(ct_hi),
        .counter_preload_low(ct_lo), .interrupt_vector(ivec), .channel_status(chst), .irq);

    task automatic check(input dpir_byte_t seen, input dpir_byte_t exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input dpir_addr_t a, input dpir_byte_t exp);
        exp_q.push_back(exp);
        u_host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic wr(input dpir_addr_t a, input dpir_byte_t v);
        u_host.xfer(1'b1, a, v);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic dpir_byte_t pins(input dpir_byte_t rt, input dpir_byte_t gb,
        input logic [12:0] s);
        dpir_byte_t p;
        logic [3:0] c3, c2;
        p = gb;
        p[7] = rt[7] ? s[4] : gb[7];
        p[6] = rt[6] ? s[0] : gb[6];
        p[5] = rt[5] ? s[5] : gb[5];
        p[4] = rt[4] ? s[1] : gb[4];
        c3 = {s[12], s[11], s[7], gb[3]};
        c2 = {s[10], s[9], s[8], gb[2]};
        p[3] = c3[rt[3:2]];
        p[2] = c2[rt[1:0]];
        return p;
    endfunction

    // Read data stands only in the cycle after the strobe
    always @(posedge clock) begin
        rd_d <= reg_rd;
        if (rd_d)
            check(reg_rdata, exp_q.pop_front());
    end

    initial begin
        void'($urandom(32'hA383));
        tick(3);
        rst <= 1'b0;
        for (int a = 0; a < 10; a++)
            rd(4'(a), (a == 6) ? 8'h0F : 8'h00);
        #1 check(out_lines, 8'h00);
        check(ivec, 8'h0F);
        check(chst, 8'h00);
        $display("reset test done");
        for (int a = 0; a < 10; a++) begin
            d = 8'($urandom);
            wr(4'(a), d);
            rd(4'(a), (a == 1) ? {4'h0, in_l} : (a == 2 || a > 7) ? 8'h00 : d);
        end
        $display("register test done");
        for (int i = 0; i < 8; i++) begin
            r = {4'($urandom), 2'(i), 2'(i)};
            g = 8'($urandom);
            wr(`DPIR_OFS_ROUTING, r);
            wr(`DPIR_OFS_GEN_OUT, g);
            src <= 13'($urandom);
            tick(2);
            #1 check(out_lines, pins(r, g, src));
        end
        $display("routing test done");
        src <= '0;
        wr(`DPIR_OFS_ENABLES, 8'h00);
        wr(`DPIR_OFS_FLAGS, 8'hFF);
        rd(`DPIR_OFS_FLAGS, 8'h00);
        for (int b = 0; b < 7; b++) begin
            src[b] <= 1'b1;
            rd(`DPIR_OFS_FLAGS, 8'(1 << b));
            src[b] <= 1'b0;
            #1 check({7'h00, irq}, 8'h00);
            wr(`DPIR_OFS_ENABLES, 8'(1 << b));
            tick(1);
            #1 check({7'h00, irq}, 8'h01);
            wr(`DPIR_OFS_FLAGS, 8'(1 << b));
            tick(1);
            #1 check({7'h00, irq}, 8'h00);
            rd(`DPIR_OFS_FLAGS, 8'h00);
        end
        $display("interrupt test done");
        for (int i = 0; i < 3; i++) begin
            g = 8'($urandom_range(1, 15));
            in_l <= in_l ^ g[3:0];
            tick(4);
            rd(`DPIR_OFS_CHANGE, {g[3:0], in_l});
            rd(`DPIR_OFS_FLAGS, 8'h80);
            rd(`DPIR_OFS_CHANGE, {4'h0, in_l});
            wr(`DPIR_OFS_FLAGS, 8'h80);
        end
        $display("input change test done");
        // Reset in mid-run after routing, vector and enables were changed
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++)
            rd(4'(a), (a == 1) ? {4'h0, in_l} : (a == 6) ? 8'h0F : 8'h00);
        #1 check(out_lines, 8'h00);
        check({7'h00, irq}, 8'h00);
        $display("second reset test done");
        wrap_up();
    end

    initial begin
        tick(2000);
        num_errors++;
        wrap_up();
    end
endmodule
